// ---- src/core_divider.sv ----
// divide-by-13 core cycle strobe generator
`timescale 1ns/1ps
module core_divider (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strobe
   output logic cycle_tick
);
   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } div_t;
   div_t d_ff, nxt_d;
   always_comb begin
      nxt_d = d_ff;
      nxt_d.tick = (d_ff.cnt == ctx_pkg::DIV_LAST);
      nxt_d.cnt = nxt_d.tick ? 4'h0 : d_ff.cnt + 4'h1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d_ff <= '0;
      end else begin
         d_ff <= nxt_d;
      end
   end
   assign cycle_tick = d_ff.tick;
endmodule

// ---- src/cpu_context_regs.sv ----
// programmer-visible core registers, banked flags and return stack
`timescale 1ns/1ps
// Overview of operation
// - sum register at data address ff
// - pointer registers at data addresses 80, 81
// - short registers at data addresses 82, 83
// - short register operand: one byte, four cycles
// - 12-bit instruction pointer, advances after fetch
// - pointer loads jump, call, vector, reset, pop
// - relative branch adds signed offset via alu
// - three flag pairs, active context only used
// - interrupt entry switches pair, return restores
// - pairs kept across switches, own-context access
// - carry from carry, borrow, bit test, rotate
// - zero set when result equals zero
// - reset starts in top-priority context
// - push shifts levels down, sixth lost
// - return pops level one, shifts up
// - over six nested pushes saturates depth
// - return on empty stack continues sequentially
// - only instruction pointer is pushed
// - core cycle is internal clock over 13
// - instructions take two, four or five cycles
// - reset empties the return stack
// - reset loads pointer from vector fff e
module cpu_context_regs (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // instruction pointer control
   input wire logic IP_STEP,
   input wire logic [7:0] IP_CMD,
   input wire logic [11:0] IP_TARGET,
   input wire logic [7:0] BRANCH_OFS,
   input wire logic BRANCH_EN,
   input wire logic BRANCH_SUB,
   // data space bus
   input wire logic [7:0] DS_ADDR,
   input wire logic DS_WR,
   input wire logic DS_RD,
   input wire logic [7:0] DS_WDATA,
   // alu write-back
   input wire logic SUM_WR,
   input wire logic [7:0] SUM_WDATA,
   // flag update
   input wire logic ARITH_UPD,
   input wire logic ARITH_CARRY,
   input wire logic LOGIC_UPD,
   input wire logic [7:0] RESULT,
   input wire logic BITTEST_UPD,
   input wire logic BITTEST_VAL,
   input wire logic ROTATE_UPD,
   input wire logic ROTATE_OUT,
   // instruction timing
   input wire logic INSTR_START,
   input wire logic [2:0] INSTR_LEN,
   // outputs
   output logic [11:0] INSTRUCTION_POINTER,
   output logic [7:0] DS_RDATA,
   output logic DS_HIT,
   output logic [7:0] SUM_VALUE,
   output logic [7:0] FIRST_POINTER,
   output logic [7:0] SECOND_POINTER,
   output logic [7:0] FIRST_SHORT,
   output logic [7:0] SECOND_SHORT,
   output logic CARRY_OUT,
   output logic ZERO_OUT,
   output logic [2:0] CONTEXT,
   output logic [2:0] STACK_DEPTH,
   output logic CORE_TICK,
   output logic INSTR_DONE,
   output logic LEN_ERR
);
   typedef struct packed {
      logic [11:0] ip;
      logic [7:0] sum;
      logic [7:0] ptr0;
      logic [7:0] ptr1;
      logic [7:0] sh0;
      logic [7:0] sh1;
      logic main_borrow_bit;
      logic main_null_bit;
      logic irq_borrow_bit;
      logic irq_null_bit;
      logic top_borrow_bit;
      logic top_null_bit;
      ctx_pkg::ctx_t ctx;
      ctx_pkg::ctx_t prev_ctx;
      logic [7:0] rdata;
      logic hit;
      logic carry;
      logic zero;
      logic [2:0] cyc_left;
      logic done;
      logic len_err;
      logic tick;
      logic [2:0] depth;
   } core_t;
   core_t s_ff, nxt_s;
   logic tick;
   logic push;
   logic pop;
   logic [11:0] stk_top;
   logic stk_empty;
   logic [2:0] stk_depth;
   logic [11:0] ofs_ext;
   logic cur_c;
   logic cur_z;
   logic new_c;
   logic new_z;
   logic ctx_back;
   logic step;
   core_divider u_div (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .cycle_tick(tick)
   );
   assign step = IP_STEP;
   assign push = step && (IP_CMD == ctx_pkg::IP_CALL || IP_CMD == ctx_pkg::IP_IRQ ||
                          IP_CMD == ctx_pkg::IP_NMI);
   assign pop = step && (IP_CMD == ctx_pkg::IP_RETURN_SUB ||
                         IP_CMD == ctx_pkg::IP_RETURN_IRQ);
   return_stack u_stack (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .push(push),
      .pop(pop),
      .push_data(s_ff.ip),
      .top_data(stk_top),
      .empty(stk_empty),
      .depth(stk_depth)
   );
   assign ofs_ext = {{4{BRANCH_OFS[7]}}, BRANCH_OFS};
   always_comb begin
      nxt_s = s_ff;
      ctx_back = 1'b0;
      cur_c = 1'b0;
      cur_z = 1'b0;
      new_c = 1'b0;
      new_z = 1'b0;
      nxt_s.tick = tick;
      // instruction pointer sources
      if (step) begin
         unique case (IP_CMD)
            ctx_pkg::IP_HOLD: nxt_s.ip = s_ff.ip;
            ctx_pkg::IP_INC: begin
               if (BRANCH_EN) begin
                  nxt_s.ip = BRANCH_SUB ? s_ff.ip - ofs_ext : s_ff.ip + ofs_ext;
               end else begin
                  nxt_s.ip = s_ff.ip + 12'h001;
               end
            end
            ctx_pkg::IP_JUMP: nxt_s.ip = IP_TARGET;
            ctx_pkg::IP_CALL: nxt_s.ip = IP_TARGET;
            ctx_pkg::IP_IRQ: nxt_s.ip = IP_TARGET;
            ctx_pkg::IP_NMI: nxt_s.ip = IP_TARGET;
            ctx_pkg::IP_RETURN_SUB, ctx_pkg::IP_RETURN_IRQ: begin
               nxt_s.ip = stk_empty ? s_ff.ip + 12'h001 : stk_top;
               ctx_back = (IP_CMD == ctx_pkg::IP_RETURN_IRQ);
            end
            default: nxt_s.ip = s_ff.ip;
         endcase
      end
      // active pair read
      unique case (s_ff.ctx)
         ctx_pkg::CTX_MAIN: begin
            cur_c = s_ff.main_borrow_bit;
            cur_z = s_ff.main_null_bit;
         end
         ctx_pkg::CTX_IRQ: begin
            cur_c = s_ff.irq_borrow_bit;
            cur_z = s_ff.irq_null_bit;
         end
         ctx_pkg::CTX_TOP: begin
            cur_c = s_ff.top_borrow_bit;
            cur_z = s_ff.top_null_bit;
         end
         default: begin
            cur_c = 1'b0;
            cur_z = 1'b0;
         end
      endcase
      new_c = cur_c;
      new_z = cur_z;
      if (ARITH_UPD) begin
         new_c = ARITH_CARRY;
         new_z = (RESULT == 8'h00);
      end else if (LOGIC_UPD) begin
         new_z = (RESULT == 8'h00);
      end else if (ROTATE_UPD) begin
         new_c = ROTATE_OUT;
         new_z = (RESULT == 8'h00);
      end
      if (BITTEST_UPD) begin
         new_c = BITTEST_VAL;
      end
      // only the active pair is written
      unique case (s_ff.ctx)
         ctx_pkg::CTX_MAIN: begin
            nxt_s.main_borrow_bit = new_c;
            nxt_s.main_null_bit = new_z;
         end
         ctx_pkg::CTX_IRQ: begin
            nxt_s.irq_borrow_bit = new_c;
            nxt_s.irq_null_bit = new_z;
         end
         ctx_pkg::CTX_TOP: begin
            nxt_s.top_borrow_bit = new_c;
            nxt_s.top_null_bit = new_z;
         end
         default: nxt_s.ctx = ctx_pkg::CTX_TOP;
      endcase
      // context switching leaves every pair untouched
      if (step && IP_CMD == ctx_pkg::IP_NMI) begin
         nxt_s.prev_ctx = s_ff.ctx;
         nxt_s.ctx = ctx_pkg::CTX_TOP;
      end else if (step && IP_CMD == ctx_pkg::IP_IRQ) begin
         nxt_s.prev_ctx = s_ff.ctx;
         nxt_s.ctx = ctx_pkg::CTX_IRQ;
      end else if (ctx_back) begin
         // one level of history; further returns fall back to main
         nxt_s.ctx = s_ff.prev_ctx;
         nxt_s.prev_ctx = ctx_pkg::CTX_MAIN;
      end
      // data space writes, bus write wins over alu write-back
      if (SUM_WR) begin
         nxt_s.sum = SUM_WDATA;
      end
      if (DS_WR) begin
         unique case (DS_ADDR)
            ctx_pkg::ADDR_SUM: nxt_s.sum = DS_WDATA;
            ctx_pkg::ADDR_FIRST_POINTER: nxt_s.ptr0 = DS_WDATA;
            ctx_pkg::ADDR_SECOND_POINTER: nxt_s.ptr1 = DS_WDATA;
            ctx_pkg::ADDR_FIRST_SHORT: nxt_s.sh0 = DS_WDATA;
            ctx_pkg::ADDR_SECOND_SHORT: nxt_s.sh1 = DS_WDATA;
            default: nxt_s.sum = nxt_s.sum;
         endcase
      end
      // data space reads return the live value
      nxt_s.hit = DS_RD && ctx_pkg::is_mapped(DS_ADDR);
      unique case (DS_ADDR)
         ctx_pkg::ADDR_SUM: nxt_s.rdata = s_ff.sum;
         ctx_pkg::ADDR_FIRST_POINTER: nxt_s.rdata = s_ff.ptr0;
         ctx_pkg::ADDR_SECOND_POINTER: nxt_s.rdata = s_ff.ptr1;
         ctx_pkg::ADDR_FIRST_SHORT: nxt_s.rdata = s_ff.sh0;
         ctx_pkg::ADDR_SECOND_SHORT: nxt_s.rdata = s_ff.sh1;
         default: nxt_s.rdata = 8'h00;
      endcase
      if (!DS_RD) begin
         nxt_s.rdata = 8'h00;
      end
      // instruction length in core cycles
      nxt_s.done = 1'b0;
      if (INSTR_START) begin
         nxt_s.len_err = !(INSTR_LEN == ctx_pkg::CYC_SHORT || INSTR_LEN == ctx_pkg::CYC_MID ||
                           INSTR_LEN == ctx_pkg::CYC_LONG);
         nxt_s.cyc_left = nxt_s.len_err ? ctx_pkg::CYC_ONE_BYTE_SHORT : INSTR_LEN;
      end else if (tick && s_ff.cyc_left != 3'h0) begin
         nxt_s.cyc_left = s_ff.cyc_left - 3'h1;
         nxt_s.done = (s_ff.cyc_left == 3'h1);
      end
      nxt_s.carry = new_c;
      nxt_s.zero = new_z;
      if (nxt_s.ctx != s_ff.ctx) begin
         unique case (nxt_s.ctx)
            ctx_pkg::CTX_MAIN: begin
               nxt_s.carry = s_ff.main_borrow_bit;
               nxt_s.zero = s_ff.main_null_bit;
            end
            ctx_pkg::CTX_IRQ: begin
               nxt_s.carry = s_ff.irq_borrow_bit;
               nxt_s.zero = s_ff.irq_null_bit;
            end
            default: begin
               nxt_s.carry = s_ff.top_borrow_bit;
               nxt_s.zero = s_ff.top_null_bit;
            end
         endcase
      end
      nxt_s.depth = stk_depth;
   end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_ff <= '0;
         s_ff.ip <= ctx_pkg::RESET_VECTOR;
         s_ff.ctx <= ctx_pkg::CTX_TOP;
         s_ff.prev_ctx <= ctx_pkg::CTX_MAIN;
         s_ff.sum <= ctx_pkg::REG_RESET;
         s_ff.cyc_left <= 3'h0;
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign INSTRUCTION_POINTER = s_ff.ip;
   assign DS_RDATA = s_ff.rdata;
   assign DS_HIT = s_ff.hit;
   assign SUM_VALUE = s_ff.sum;
   assign FIRST_POINTER = s_ff.ptr0;
   assign SECOND_POINTER = s_ff.ptr1;
   assign FIRST_SHORT = s_ff.sh0;
   assign SECOND_SHORT = s_ff.sh1;
   assign CARRY_OUT = s_ff.carry;
   assign ZERO_OUT = s_ff.zero;
   assign CONTEXT = s_ff.ctx;
   assign STACK_DEPTH = s_ff.depth;
   assign CORE_TICK = s_ff.tick;
   assign INSTR_DONE = s_ff.done;
   assign LEN_ERR = s_ff.len_err;
endmodule

// ---- src/ctx_pkg.sv ----
// shared constants and types for the core context block
package ctx_pkg;
   localparam logic [7:0] ADDR_FIRST_POINTER = 8'h80;
   localparam logic [7:0] ADDR_SECOND_POINTER = 8'h81;
   localparam logic [7:0] ADDR_FIRST_SHORT = 8'h82;
   localparam logic [7:0] ADDR_SECOND_SHORT = 8'h83;
   localparam logic [7:0] ADDR_SUM = 8'hff;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [11:0] RESET_VECTOR = 12'hffe;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam int STACK_DEPTH = 6;
   localparam logic [2:0] DEPTH_MAX = 3'h6;
   localparam logic [2:0] DEPTH_EMPTY = 3'h0;
   localparam int CORE_DIV = 13;
   localparam logic [3:0] DIV_LAST = 4'hc;
   localparam logic [2:0] CYC_SHORT = 3'h2;
   localparam logic [2:0] CYC_MID = 3'h4;
   localparam logic [2:0] CYC_LONG = 3'h5;
   localparam logic [2:0] CYC_ONE_BYTE_SHORT = 3'h4;
   // instruction pointer update command
   typedef enum logic [7:0] {
      IP_HOLD   = 8'h01,
      IP_INC    = 8'h02,
      IP_JUMP   = 8'h04,
      IP_CALL   = 8'h08,
      IP_IRQ    = 8'h10,
      IP_NMI    = 8'h20,
      IP_RETURN_SUB = 8'h40,
      IP_RETURN_IRQ = 8'h80
   } ip_cmd_t;
   // flag context, one-hot
   typedef enum logic [2:0] {
      CTX_MAIN = 3'h1,
      CTX_IRQ  = 3'h2,
      CTX_TOP  = 3'h4
   } ctx_t;
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_FIRST_POINTER) || (a == ADDR_SECOND_POINTER) ||
                  (a == ADDR_FIRST_SHORT) || (a == ADDR_SECOND_SHORT) || (a == ADDR_SUM);
   endfunction
endpackage

// ---- src/ret_stack.sv ----
// six-level 12-bit return stack with saturating depth
`timescale 1ns/1ps
module return_stack (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic push,
   input wire logic pop,
   input wire logic [11:0] push_data,
   // state
   output logic [11:0] top_data,
   output logic empty,
   output logic [2:0] depth
);
   typedef struct packed {
      logic [ctx_pkg::STACK_DEPTH-1:0][11:0] lvl;
      logic [2:0] depth;
      logic [11:0] top;
   } stk_t;
   stk_t st_ff, nxt_st;
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         for (int i = ctx_pkg::STACK_DEPTH - 1; i > 0; i--) begin
            nxt_st.lvl[i] = st_ff.lvl[i-1];
         end
         nxt_st.lvl[0] = push_data;
         if (st_ff.depth != ctx_pkg::DEPTH_MAX) begin
            nxt_st.depth = st_ff.depth + 3'h1;
         end
      end else if (pop && st_ff.depth != ctx_pkg::DEPTH_EMPTY) begin
         for (int i = 0; i < ctx_pkg::STACK_DEPTH - 1; i++) begin
            nxt_st.lvl[i] = st_ff.lvl[i+1];
         end
         nxt_st.depth = st_ff.depth - 3'h1;
      end
      nxt_st.top = nxt_st.lvl[0];
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign top_data = st_ff.top;
   assign empty = (st_ff.depth == ctx_pkg::DEPTH_EMPTY);
   assign depth = st_ff.depth;
endmodule

// ---- verification/cpu_context_regs_tb.sv ----
// self-checking bench for the core context block
`timescale 1ns/1ps
module cpu_context_regs_tb;
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic IP_STEP = 1'b0, BRANCH_EN = 1'b0, BRANCH_SUB = 1'b0, SUM_WR = 1'b0;
   logic [7:0] IP_CMD = 8'h01, BRANCH_OFS = 8'h00, SUM_WDATA = 8'h00, RESULT = 8'h00;
   logic [11:0] IP_TARGET = 12'h000;
   logic ARITH_UPD = 1'b0, ARITH_CARRY = 1'b0, LOGIC_UPD = 1'b0, BITTEST_UPD = 1'b0;
   logic BITTEST_VAL = 1'b0, ROTATE_UPD = 1'b0, ROTATE_OUT = 1'b0, INSTR_START = 1'b0;
   logic [2:0] INSTR_LEN = 3'h2;
   logic [7:0] DS_ADDR, DS_WDATA, DS_RDATA, SUM_VALUE, FIRST_POINTER, SECOND_POINTER;
   logic [7:0] FIRST_SHORT, SECOND_SHORT;
   logic DS_WR, DS_RD, DS_HIT, CARRY_OUT, ZERO_OUT, CORE_TICK, INSTR_DONE, LEN_ERR;
   logic [11:0] INSTRUCTION_POINTER;
   logic [2:0] CONTEXT, STACK_DEPTH;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   cpu_context_regs dut (.*);
   ds_master u_ds (.clk(CORE_CLK), .ds_addr(DS_ADDR), .ds_wr(DS_WR), .ds_rd(DS_RD),
      .ds_wdata(DS_WDATA), .ds_rdata(DS_RDATA), .ds_hit(DS_HIT));
   always #50 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one pointer command; tgt low byte doubles as branch offset
   task automatic step(input logic [7:0] cmd, input logic [11:0] tgt, input logic be,
         input logic sub);
      @(posedge CORE_CLK);
      IP_STEP <= 1'b1;
      IP_CMD <= cmd;
      IP_TARGET <= tgt;
      BRANCH_OFS <= tgt[7:0];
      BRANCH_EN <= be;
      BRANCH_SUB <= sub;
      @(posedge CORE_CLK);
      IP_STEP <= 1'b0;
      BRANCH_EN <= 1'b0;
      #1;
   endtask
   // k = arith, logic, rotate, bit test
   task automatic upd(input logic [3:0] k, input logic c, input logic [7:0] r);
      @(posedge CORE_CLK);
      {ARITH_UPD, LOGIC_UPD, ROTATE_UPD, BITTEST_UPD} <= k;
      {ARITH_CARRY, ROTATE_OUT, BITTEST_VAL} <= {3{c}};
      RESULT <= r;
      @(posedge CORE_CLK);
      {ARITH_UPD, LOGIC_UPD, ROTATE_UPD, BITTEST_UPD} <= 4'h0;
      #1;
   endtask
   task automatic flags(input logic c, input logic z);
      chk("carry", {11'h000, c}, {11'h000, CARRY_OUT});
      chk("zero", {11'h000, z}, {11'h000, ZERO_OUT});
   endtask
   task automatic t_reset();
      chk("ip", 12'hffe, INSTRUCTION_POINTER);
      chk("context", 12'h004, {9'h000, CONTEXT});
      chk("depth", 12'h000, {9'h000, STACK_DEPTH});
      $display("reset test done");
   endtask
   task automatic t_flags();
      upd(4'h8, 1'b1, 8'h00);
      flags(1'b1, 1'b1);
      step(8'h10, 12'h0f0, 1'b0, 1'b0);
      chk("context", 12'h002, {9'h000, CONTEXT});
      chk("ip", 12'h0f0, INSTRUCTION_POINTER);
      flags(1'b0, 1'b0);
      upd(4'h4, 1'b1, 8'h05);
      flags(1'b0, 1'b0);
      upd(4'h1, 1'b1, 8'h05);
      flags(1'b1, 1'b0);
      upd(4'h2, 1'b0, 8'h00);
      flags(1'b0, 1'b1);
      step(8'h80, 12'h000, 1'b0, 1'b0);
      chk("context", 12'h004, {9'h000, CONTEXT});
      chk("ip", 12'hffe, INSTRUCTION_POINTER);
      flags(1'b1, 1'b1);
      step(8'h80, 12'h000, 1'b0, 1'b0);
      chk("context", 12'h001, {9'h000, CONTEXT});
      chk("ip", 12'hfff, INSTRUCTION_POINTER);
      flags(1'b0, 1'b0);
      step(8'h20, 12'h0fc, 1'b0, 1'b0);
      chk("context", 12'h004, {9'h000, CONTEXT});
      flags(1'b1, 1'b1);
      step(8'h80, 12'h000, 1'b0, 1'b0);
      chk("context", 12'h001, {9'h000, CONTEXT});
      $display("flag test done");
   endtask
   task automatic t_regs();
      logic [7:0] q;
      logic h;
      logic [7:0] ra [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
      logic [7:0] re [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h5a, 8'h00};
      @(posedge CORE_CLK);
      SUM_WR <= 1'b1;
      SUM_WDATA <= 8'hc3;
      @(posedge CORE_CLK);
      SUM_WR <= 1'b0;
      #1;
      chk("alu sum", 12'h0c3, {4'h0, SUM_VALUE});
      for (int i = 0; i < 6; i++) begin
         u_ds.access(1'b1, ra[i], re[i] | 8'(i == 5), q, h);
      end
      chk("first_pointer", 12'h011, {4'h0, FIRST_POINTER});
      chk("second_pointer", 12'h022, {4'h0, SECOND_POINTER});
      chk("first_short", 12'h033, {4'h0, FIRST_SHORT});
      chk("second_short", 12'h044, {4'h0, SECOND_SHORT});
      for (int i = 0; i < 6; i++) begin
         u_ds.access(1'b0, ra[i], 8'h00, q, h);
         chk("read data", {4'h0, re[i]}, {4'h0, q});
         chk("read hit", {11'h000, i < 5}, {11'h000, h});
      end
      $display("register test done");
   endtask
   task automatic t_ip();
      step(8'h04, 12'h100, 1'b0, 1'b0);
      chk("ip", 12'h100, INSTRUCTION_POINTER);
      step(8'h02, 12'h000, 1'b0, 1'b0);
      chk("ip", 12'h101, INSTRUCTION_POINTER);
      step(8'h02, 12'h010, 1'b1, 1'b0);
      chk("ip", 12'h111, INSTRUCTION_POINTER);
      step(8'h02, 12'h0f0, 1'b1, 1'b0);
      chk("ip", 12'h101, INSTRUCTION_POINTER);
      step(8'h02, 12'h020, 1'b1, 1'b1);
      chk("ip", 12'h0e1, INSTRUCTION_POINTER);
      step(8'h01, 12'h555, 1'b0, 1'b0);
      chk("ip", 12'h0e1, INSTRUCTION_POINTER);
      step(8'h04, 12'hfff, 1'b0, 1'b0);
      step(8'h02, 12'h000, 1'b0, 1'b0);
      chk("ip", 12'h000, INSTRUCTION_POINTER);
      $display("pointer test done");
   endtask
   task automatic t_stack();
      step(8'h04, 12'h200, 1'b0, 1'b0);
      for (int i = 0; i < 7; i++) begin
         step(8'h08, 12'h300 + 12'(i), 1'b0, 1'b0);
      end
      @(posedge CORE_CLK);
      #1;
      chk("depth", 12'h006, {9'h000, STACK_DEPTH});
      chk("sum kept", 12'h05a, {4'h0, SUM_VALUE});
      for (int i = 5; i >= 0; i--) begin
         step(8'h40, 12'h000, 1'b0, 1'b0);
         chk("ip", 12'h300 + 12'(i), INSTRUCTION_POINTER);
      end
      step(8'h40, 12'h000, 1'b0, 1'b0);
      chk("ip", 12'h301, INSTRUCTION_POINTER);
      @(posedge CORE_CLK);
      #1;
      chk("depth", 12'h000, {9'h000, STACK_DEPTH});
      $display("stack test done");
   endtask
   // reset in mid-run with two stacked calls and a non-top context
   task automatic t_midreset();
      step(8'h08, 12'h400, 1'b0, 1'b0);
      step(8'h08, 12'h401, 1'b0, 1'b0);
      @(posedge CORE_CLK);
      #1;
      chk("depth", 12'h002, {9'h000, STACK_DEPTH});
      @(posedge CORE_CLK);
      RST_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      #1;
      chk("ip", 12'hffe, INSTRUCTION_POINTER);
      chk("context", 12'h004, {9'h000, CONTEXT});
      chk("depth", 12'h000, {9'h000, STACK_DEPTH});
      flags(1'b0, 1'b0);
      step(8'h80, 12'h000, 1'b0, 1'b0);
      chk("ip", 12'hfff, INSTRUCTION_POINTER);
      chk("context", 12'h001, {9'h000, CONTEXT});
      $display("mid-run reset test done");
   endtask
   task automatic t_timing();
      int c [4];
      logic [2:0] lens [4] = '{3'h2, 3'h4, 3'h5, 3'h3};
      for (int k = 0; k < 4; k++) begin
         c[k] = 0;
         while (CORE_TICK !== 1'b1 && c[k] < 20) begin
            @(posedge CORE_CLK);
            #1;
            c[k]++;
         end
         c[k] = 0;
         @(posedge CORE_CLK);
         INSTR_START <= 1'b1;
         INSTR_LEN <= lens[k];
         @(posedge CORE_CLK);
         INSTR_START <= 1'b0;
         #1;
         while (INSTR_DONE !== 1'b1 && c[k] < 100) begin
            @(posedge CORE_CLK);
            #1;
            c[k]++;
         end
      end
      chk("len4 minus len2", 12'd26, 12'(c[1] - c[0]));
      chk("len5 minus len2", 12'd39, 12'(c[2] - c[0]));
      chk("length error", 12'h001, {11'h000, LEN_ERR});
      c[3] = 0;
      @(posedge CORE_CLK);
      #1;
      while (CORE_TICK !== 1'b1 && c[3] < 20) begin
         @(posedge CORE_CLK);
         #1;
         c[3]++;
      end
      c[3] = 0;
      do begin
         @(posedge CORE_CLK);
         #1;
         c[3]++;
      end while (CORE_TICK !== 1'b1 && c[3] < 20);
      chk("tick period", 12'd13, 12'(c[3]));
      $display("timing test done");
   endtask
   initial begin
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      #1;
      t_reset();
      t_flags();
      t_regs();
      t_ip();
      t_stack();
      t_midreset();
      t_timing();
      wrap_up();
   end
endmodule

// ---- verification/ctx_chk.sv ----
// assertions on the core context block ports
`timescale 1ns/1ps
module ctx_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // inputs
   input wire logic IP_STEP,
   input wire logic [7:0] IP_CMD,
   input wire logic [11:0] IP_TARGET,
   input wire logic BRANCH_EN,
   input wire logic [7:0] DS_ADDR,
   input wire logic DS_WR,
   input wire logic [7:0] DS_WDATA,
   input wire logic ARITH_UPD,
   input wire logic [7:0] RESULT,
   input wire logic INSTR_START,
   input wire logic [2:0] INSTR_LEN,
   // outputs
   input wire logic [11:0] INSTRUCTION_POINTER,
   input wire logic [7:0] SUM_VALUE,
   input wire logic ZERO_OUT,
   input wire logic [2:0] CONTEXT,
   input wire logic [2:0] STACK_DEPTH,
   input wire logic CORE_TICK,
   input wire logic LEN_ERR
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   // twelve idle clocks between core ticks
   sequence s_quiet;
      !CORE_TICK [*8] ##1 !CORE_TICK [*4];
   endsequence
   a_call_load: assert property (
      IP_STEP && IP_CMD == 8'h08 |=> INSTRUCTION_POINTER == $past(IP_TARGET))
      else $error("call target not loaded");
   a_inc_one: assert property (
      IP_STEP && IP_CMD == 8'h02 && !BRANCH_EN |=>
      INSTRUCTION_POINTER == $past(INSTRUCTION_POINTER) + 12'h001)
      else $error("pointer did not advance by one");
   a_reset_state: assert property (
      $rose(RST_N) |-> INSTRUCTION_POINTER == 12'hffe && CONTEXT == 3'h4 && STACK_DEPTH == 3'h0)
      else $error("wrong state after reset");
   a_irq_ctx: assert property (IP_STEP && IP_CMD == 8'h10 |=> CONTEXT == 3'h2)
      else $error("irq context not selected");
   a_nmi_ctx: assert property (IP_STEP && IP_CMD == 8'h20 |=> CONTEXT == 3'h4)
      else $error("nmi context not selected");
   a_depth_cap: assert property (STACK_DEPTH <= 3'h6)
      else $error("stack depth beyond six");
   a_zero_flag: assert property (
      ARITH_UPD && !IP_STEP |=> ZERO_OUT == ($past(RESULT) == 8'h00))
      else $error("zero flag wrong");
   a_sum_write: assert property (
      DS_WR && DS_ADDR == 8'hff |=> SUM_VALUE == $past(DS_WDATA))
      else $error("sum register not written");
   a_tick_period: assert property (CORE_TICK |=> s_quiet ##1 CORE_TICK)
      else $error("core tick period wrong");
   a_len_err: assert property (INSTR_START && INSTR_LEN == 3'h3 |=> LEN_ERR)
      else $error("illegal length not flagged");
endmodule
bind cpu_context_regs ctx_chk u_chk (.*);

// ---- verification/ds_master.sv ----
// data space master standing in for the sequencer's bus side
`timescale 1ns/1ps
module ds_master (
   // clock
   input wire logic clk,
   // data space bus
   output logic [7:0] ds_addr,
   output logic ds_wr,
   output logic ds_rd,
   output logic [7:0] ds_wdata,
   input wire logic [7:0] ds_rdata,
   input wire logic ds_hit
);
   initial begin
      ds_addr = 8'h00;
      ds_wr = 1'b0;
      ds_rd = 1'b0;
      ds_wdata = 8'h00;
   end
   // request held for one edge; read answer taken one cycle later
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q, output logic h);
      @(posedge clk);
      ds_addr <= a;
      ds_wr <= wr;
      ds_rd <= !wr;
      ds_wdata <= d;
      @(posedge clk);
      ds_wr <= 1'b0;
      ds_rd <= 1'b0;
      ds_addr <= ~a;
      ds_wdata <= ~d;
      #1;
      q = ds_rdata;
      h = ds_hit;
   endtask
endmodule
